// ### core/pse_map.svh
`ifndef PSE_MAP_SVH
`define PSE_MAP_SVH
`define PSE_NUM_STATES     63
`define PSE_NUM_INPUTS     10
`define PSE_NUM_DIGITAL    5
`define PSE_NUM_OUTPUTS    10
`define PSE_CLK_HZ         10000000
`define PSE_TICK_NS        10000
`define PSE_TICK_CYC       ((`PSE_TICK_NS * (`PSE_CLK_HZ / 1000000)) / 1000)
`define PSE_MAX_DELAY_MS   400
`define PSE_MAX_TICKS      ((`PSE_MAX_DELAY_MS * 1000000) / `PSE_TICK_NS)
`define PSE_LOAD_US        20
`define PSE_LOAD_CYC       ((`PSE_LOAD_US * (`PSE_CLK_HZ / 1000000)) / 2)
`define PSE_START_NS       500000
`define PSE_START_CYC      ((`PSE_START_NS / 100))
`define PSE_EDGE_MAX_US    100
`define PSE_CLK100K_HALF   50
`define PSE_RST_STATE      6'h00
`endif

// ### core/pse_pkg.sv
package pse_pkg;
  typedef enum logic [1:0] {
    PSE_SRC_ENGINE = 2'b00,
    PSE_SRC_HOST   = 2'b01,
    PSE_SRC_CLOCK  = 2'b10
  } pse_src_t;
  typedef enum logic [2:0] {
    PSE_ST_BOOT  = 3'b000,
    PSE_ST_WAIT  = 3'b001,
    PSE_ST_LOAD  = 3'b011,
    PSE_ST_RUN   = 3'b010
  } pse_fsm_t;
  // One state cell: pattern, exits, targets and timers in 10 us ticks.
  typedef struct packed {
    logic [9:0]  drive_pattern;
    logic [3:0]  seq_select;
    logic        seq_level;
    logic [15:0] seq_delay;
    logic [5:0]  seq_target;
    logic [15:0] mon_mask;
    logic [15:0] mon_expect;
    logic [5:0]  mon_target;
    logic [15:0] tmo_delay;
    logic        tmo_enable;
    logic [5:0]  tmo_target;
    logic        latch_enable;
  } pse_cell_t;
  typedef struct packed {
    logic [9:0] under_volt;
    logic [9:0] over_volt;
    logic [9:0] adc_limit;
  } pse_status_t;
endpackage : pse_pkg

// ### core/pse_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "pse_map.svh"
// Divider producing a one-cycle enable every LIMIT clocks.
module pse_tick #(
  parameter int LIMIT = 100
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic clr,
  output var  logic tick
);
  logic [15:0] cnt_r;
  // --------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------
  // Clearing realigns the tick grid to a state entry.
  always_ff @(posedge clk) begin
    if (sys_rst || clr) begin
      cnt_r <= 16'h0000;
      tick  <= 1'b0;
    end else if (cnt_r == 16'(LIMIT - 1)) begin
      cnt_r <= 16'h0000;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
      tick  <= 1'b0;
    end
  end
endmodule : pse_tick
`default_nettype wire

// ### core/pse_dig_in.sv
`timescale 1ns/1ps
`default_nettype none
`include "pse_map.svh"
// One digital input: level pass-through or edge pulse of set width.
module pse_dig_in (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       tick,
  input  wire logic       pin,
  input  wire logic       edge_mode,
  input  wire logic [3:0] width_ticks,
  output var  logic       level
);
  logic       prev_r;
  logic [3:0] left_r;
  // --------------------------------------------------------------
  // Edge pulse generator
  // --------------------------------------------------------------
  // A zero width still yields one clock so the edge is never lost.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_r <= 1'b0;
      left_r <= 4'h0;
      level  <= 1'b0;
    end else begin
      prev_r <= pin;
      if (!edge_mode) begin
        level  <= pin;
        left_r <= 4'h0;
      end else if (pin != prev_r) begin
        level  <= 1'b1;
        left_r <= width_ticks;
      end else if (left_r == 4'h0) begin
        level  <= 1'b0;
      end else if (tick) begin
        left_r <= left_r - 4'h1;
      end
    end
  end
endmodule : pse_dig_in
`default_nettype wire

// ### core/pse_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "pse_map.svh"
// Function
// - Holds 63 programmable state cells.
// - Ten fault detector outputs feed exit conditions.
// - Any state may target any state.
// - Sequence, monitor and timeout exits, own targets.
// - Both timers per state, reloaded on change.
// - Driver pattern fixed while state active.
// - State change and cell load under 20us.
// - Warnings ORed into one exit input.
// - Host jump feeds sequence and timeout exits.
// - Sequence exit on selected input, optional delay.
// - Input change during delay restarts timer.
// - Monitor exit is undelayed wide OR.
// - Timeout exit when progress missing in time.
// - Per-input fault latch, host readable.
// - Per-state latch enable preserves earlier faults.
// - Live status passes unlatched to host.
// - Host can write cells and force jumps.
// - Digital inputs level or edge pulse.
// - Driver source: engine, host bit, 100 kHz.
// - Wait 0.5 ms after config, then load.
module pse_engine (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                config_done,
  input  wire logic [9:0]          fault_detect,
  input  wire logic [4:0]          digital_pin,
  input  wire logic [4:0]          digital_edge_mode,
  input  wire logic [19:0]         digital_width,
  input  wire logic [9:0]          secondary_warn,
  input  wire logic [9:0]          adc_warn,
  input  wire pse_pkg::pse_status_t live_status,
  input  wire logic                host_jump,
  input  wire logic                cell_we,
  input  wire logic [5:0]          cell_addr,
  input  wire pse_pkg::pse_cell_t  cell_wdata,
  input  wire logic                fault_clear,
  input  wire logic [19:0]         drive_src,
  input  wire logic [9:0]          host_drive,
  output var  logic [9:0]          driver_output_n,
  output var  logic [4:0]          fault_latch_first,
  output var  logic [4:0]          fault_latch_second,
  output var  pse_pkg::pse_status_t status_r,
  output var  logic [5:0]          state_r,
  output var  logic                running_r
);
  import pse_pkg::*;

  // ----------------------------------------------------------------
  // Storage and time base
  // ----------------------------------------------------------------
  pse_cell_t  cells [0:`PSE_NUM_STATES-1];
  pse_cell_t  cur_r;
  pse_fsm_t   fsm_r;
  logic [15:0] wait_r;
  logic [15:0] seq_cnt_r;
  logic [15:0] tmo_cnt_r;
  logic        seq_prev_r;
  logic [5:0]  next_r;
  logic [9:0]  latch_r;
  logic [6:0]  clk100_r;
  logic        clk100_q_r;
  logic        tick;
  logic        entry;
  logic [4:0]  dig_level;
  logic [15:0] inputs;
  logic        warn_any;
  logic        seq_hit;
  logic        seq_exit;
  logic        mon_exit;
  logic        tmo_exit;

  assign entry = (fsm_r == PSE_ST_LOAD);

  pse_tick #(.LIMIT(`PSE_TICK_CYC)) u_tick (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clr     (entry),
    .tick    (tick)
  );

  // Five digital inputs share one parameterised cell.
  for (genvar g = 0; g < `PSE_NUM_DIGITAL; g++) begin : g_dig
    pse_dig_in u_dig (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .tick        (tick),
      .pin         (digital_pin[g]),
      .edge_mode   (digital_edge_mode[g]),
      .width_ticks (digital_width[4*g +: 4]),
      .level       (dig_level[g])
    );
  end

  // ----------------------------------------------------------------
  // Engine inputs
  // ----------------------------------------------------------------
  // Index 10 is the warning OR, 11..15 the digital blocks.
  assign warn_any = |secondary_warn | |adc_warn;
  assign inputs   = {dig_level, warn_any, fault_detect};

  // ----------------------------------------------------------------
  // Exit detectors
  // ----------------------------------------------------------------
  assign seq_hit  = (inputs[cur_r.seq_select] == cur_r.seq_level);
  // A zero delay exits at once; otherwise the count must complete.
  assign seq_exit = host_jump ||
                    (seq_hit && seq_cnt_r >= cur_r.seq_delay);
  assign mon_exit = |((inputs ^ cur_r.mon_expect) & cur_r.mon_mask);
  assign tmo_exit = host_jump ||
                    (cur_r.tmo_enable &&
                     tmo_cnt_r >= cur_r.tmo_delay);

  // Cell writes come from the host side; loads read the array.
  always_ff @(posedge clk) begin
    if (cell_we) begin
      cells[cell_addr] <= cell_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Control sequence
  // ----------------------------------------------------------------
  // Load takes one cycle, far inside the transition budget.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fsm_r     <= PSE_ST_BOOT;
      wait_r    <= 16'h0000;
      state_r   <= `PSE_RST_STATE;
      next_r    <= `PSE_RST_STATE;
      cur_r     <= '0;
      running_r <= 1'b0;
    end else begin
      case (fsm_r)
        PSE_ST_BOOT: begin
          if (config_done) begin
            fsm_r  <= PSE_ST_WAIT;
            wait_r <= 16'h0000;
          end
        end
        PSE_ST_WAIT: begin
          if (wait_r == 16'(`PSE_START_CYC - 1)) begin
            fsm_r <= PSE_ST_LOAD;
          end else begin
            wait_r <= wait_r + 16'h0001;
          end
        end
        PSE_ST_LOAD: begin
          cur_r     <= cells[next_r];
          state_r   <= next_r;
          running_r <= 1'b1;
          fsm_r     <= PSE_ST_RUN;
        end
        PSE_ST_RUN: begin
          if (mon_exit) begin
            next_r <= cur_r.mon_target;
            fsm_r  <= PSE_ST_LOAD;
          end else if (tmo_exit) begin
            next_r <= cur_r.tmo_target;
            fsm_r  <= PSE_ST_LOAD;
          end else if (seq_exit) begin
            next_r <= cur_r.seq_target;
            fsm_r  <= PSE_ST_LOAD;
          end
        end
        default: fsm_r <= PSE_ST_BOOT;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  // Both counts restart on each entry so stale time never carries.
  always_ff @(posedge clk) begin
    if (sys_rst || entry) begin
      seq_cnt_r  <= 16'h0000;
      tmo_cnt_r  <= 16'h0000;
      seq_prev_r <= 1'b0;
    end else if (fsm_r == PSE_ST_RUN) begin
      seq_prev_r <= seq_hit;
      if (!seq_hit || (seq_hit != seq_prev_r)) begin
        seq_cnt_r <= 16'h0000;
      end else if (tick && seq_cnt_r != 16'hffff) begin
        seq_cnt_r <= seq_cnt_r + 16'h0001;
      end
      if (tick && tmo_cnt_r != 16'hffff) begin
        tmo_cnt_r <= tmo_cnt_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Fault latch and status
  // ----------------------------------------------------------------
  // A new fault wins over a host clear in the same cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latch_r <= 10'h000;
    end else begin
      latch_r <= (fault_clear ? 10'h000 : latch_r) |
                 ((running_r && cur_r.latch_enable) ?
                  fault_detect : 10'h000);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fault_latch_first  <= 5'h00;
      fault_latch_second <= 5'h00;
      status_r           <= '0;
    end else begin
      fault_latch_first  <= latch_r[4:0];
      fault_latch_second <= latch_r[9:5];
      status_r           <= live_status;
    end
  end

  // ----------------------------------------------------------------
  // Driver outputs
  // ----------------------------------------------------------------
  // Free-running 100 kHz square wave from the 10 MHz clock.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clk100_r   <= 7'h00;
      clk100_q_r <= 1'b0;
    end else if (clk100_r == 7'(`PSE_CLK100K_HALF - 1)) begin
      clk100_r   <= 7'h00;
      clk100_q_r <= ~clk100_q_r;
    end else begin
      clk100_r <= clk100_r + 7'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      driver_output_n <= 10'h000;
    end else begin
      for (int i = 0; i < `PSE_NUM_OUTPUTS; i++) begin
        case (pse_src_t'(drive_src[2*i +: 2]))
          PSE_SRC_ENGINE: driver_output_n[i] <=
                            running_r & cur_r.drive_pattern[i];
          PSE_SRC_HOST:   driver_output_n[i] <= host_drive[i];
          PSE_SRC_CLOCK:  driver_output_n[i] <= clk100_q_r;
          default:        driver_output_n[i] <= 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence load_then_run_s;
    fsm_r == PSE_ST_LOAD ##1 fsm_r == PSE_ST_RUN;
  endsequence

  property mon_first_p;
    @(posedge clk) disable iff (sys_rst)
      (fsm_r == PSE_ST_RUN && mon_exit) |=> next_r == $past(cur_r.mon_target);
  endproperty
  mon_priority_a: assert property (mon_first_p)
    else $error("monitor exit did not win");

  tmo_target_a: assert property (@(posedge clk) disable iff (sys_rst)
    (fsm_r == PSE_ST_RUN && !mon_exit && tmo_exit)
    |=> next_r == $past(cur_r.tmo_target))
    else $error("timeout target wrong");

  seq_target_a: assert property (@(posedge clk) disable iff (sys_rst)
    (fsm_r == PSE_ST_RUN && !mon_exit && !tmo_exit && seq_exit)
    |=> next_r == $past(cur_r.seq_target))
    else $error("sequence target wrong");

  fast_load_a: assert property (@(posedge clk) disable iff (sys_rst)
    (fsm_r == PSE_ST_RUN && mon_exit) |=> load_then_run_s)
    else $error("state load too slow");

  timer_reload_a: assert property (@(posedge clk) disable iff (sys_rst)
    entry |=> seq_cnt_r == 16'h0000 && tmo_cnt_r == 16'h0000)
    else $error("timers not reloaded");

  seq_restart_a: assert property (@(posedge clk) disable iff (sys_rst)
    (fsm_r == PSE_ST_RUN && !seq_hit) |=> seq_cnt_r == 16'h0000)
    else $error("sequence timer not restarted");

  latch_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!fault_clear && !cur_r.latch_enable) |=> latch_r == $past(latch_r))
    else $error("fault latch changed while disabled");

  latch_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    (running_r && cur_r.latch_enable && fault_detect[0])
    |=> latch_r[0] ##1 fault_latch_first[0])
    else $error("fault bit not latched");

  start_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
    (fsm_r == PSE_ST_BOOT && config_done) |=> !running_r [*8])
    else $error("engine started too early");

  pattern_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    (fsm_r == PSE_ST_RUN && $stable(fsm_r)) |-> $stable(cur_r.drive_pattern))
    else $error("pattern changed inside state");

  // ----------------------------------------------------------------
  // Checks on start, host paths and inputs
  // ----------------------------------------------------------------
  // The start wait must end in one load and then the first state.
  start_load_a: assert property (@(posedge clk) disable iff (sys_rst)
    (fsm_r == PSE_ST_WAIT && wait_r == 16'(`PSE_START_CYC - 1))
    |=> load_then_run_s)
    else $error("first state not loaded after wait");

  host_jump_a: assert property (@(posedge clk) disable iff (sys_rst)
    (fsm_r == PSE_ST_RUN && host_jump) |=> load_then_run_s)
    else $error("host jump did not leave the state");

  latch_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    (fault_clear && !(running_r && cur_r.latch_enable))
    |=> latch_r == 10'h000)
    else $error("fault latch not cleared");

  // Ticks must stay far apart; a clear only ever delays the next one.
  tick_space_a: assert property (@(posedge clk) disable iff (sys_rst)
    tick |=> !tick [*8])
    else $error("time base ticks too close");

  // A level input follows its pin one clock late, with no filtering.
  level_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
    !digital_edge_mode[0] |=> dig_level[0] == $past(digital_pin[0]))
    else $error("level input not passed through");

  edge_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    (digital_edge_mode[1] && !$past(sys_rst) &&
     digital_pin[1] != $past(digital_pin[1])) |=> dig_level[1])
    else $error("edge gave no pulse");

  // The source select must route the chosen data onto the pin.
  src_host_a: assert property (@(posedge clk) disable iff (sys_rst)
    (pse_src_t'(drive_src[1:0]) == PSE_SRC_HOST)
    |=> driver_output_n[0] == $past(host_drive[0]))
    else $error("host bit not on driver output");

  src_clock_a: assert property (@(posedge clk) disable iff (sys_rst)
    (pse_src_t'(drive_src[3:2]) == PSE_SRC_CLOCK)
    |=> driver_output_n[1] == $past(clk100_q_r))
    else $error("clock not on driver output");
endmodule : pse_engine
`default_nettype wire

// ### test/pse_supply_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Supply regulator model
// ------------------------------------------------------------
// One regulator behind a driver output: good RAMP cycles after enable.
module pse_supply_model #(
  parameter int RAMP = 50
) (
  input  wire logic clk,
  input  wire logic enable,
  input  wire logic kill,
  output var  logic fault
);
  int unsigned ramp_r = 0;
  // Soft start restarts whenever the enable drops, as a real LDO does.
  always_ff @(posedge clk) begin
    if (!enable) ramp_r <= 0;
    else if (ramp_r < RAMP) ramp_r <= ramp_r + 1;
  end
  // A forced short shows as a fault at once; the detector has no filter.
  always_comb begin
    fault = kill || (ramp_r < RAMP);
  end
endmodule : pse_supply_model
`default_nettype wire

// ### test/pse_engine_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin \
  fails++; $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
module pse_engine_tb_top;
  import pse_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic clk = 0, sys_rst, config_done, host_jump, cell_we, fault_clear;
  logic kill, mdl_flt;
  logic [8:0]  tb_flt;
  logic [4:0]  digital_pin, fault_latch_first, fault_latch_second;
  logic [9:0]  secondary_warn, host_drive, driver_output_n;
  logic [5:0]  cell_addr, state_r;
  logic [19:0] drive_src;
  logic        running_r;
  pse_cell_t   cell_wdata;
  pse_status_t live_status, status_r;
  int fails = 0, n_checks = 0;
  // Clock of 100 ns period.
  always #50 clk = ~clk;
  pse_supply_model u_pse_supply_model (.clk(clk),
    .enable(driver_output_n[0]), .kill(kill), .fault(mdl_flt));
  pse_engine u_pse_engine (.clk(clk), .sys_rst(sys_rst),
    .config_done(config_done), .fault_detect({tb_flt, mdl_flt}),
    .digital_pin(digital_pin), .digital_edge_mode(5'h02),
    .digital_width(20'h0_0020), .secondary_warn(secondary_warn),
    .adc_warn(10'h000), .live_status(live_status), .host_jump(host_jump),
    .cell_we(cell_we), .cell_addr(cell_addr), .cell_wdata(cell_wdata),
    .fault_clear(fault_clear), .drive_src(drive_src),
    .host_drive(host_drive), .driver_output_n(driver_output_n),
    .fault_latch_first(fault_latch_first),
    .fault_latch_second(fault_latch_second), .status_r(status_r),
    .state_r(state_r), .running_r(running_r));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic step(int n = 1);
    repeat (n) begin @(posedge clk); #1; end
  endtask : step
  task automatic wait_state(logic [5:0] ex, int lim);
    int k;
    k = 0;
    while (state_r !== ex && k < lim) begin step(); k++; end
    `CHK("state_r", ex, state_r)
  endtask : wait_state
  // Mon_expect is always zero: a clear detector reads as good.
  task automatic wr(logic [5:0] a, logic [9:0] pat, logic [3:0] ss,
    logic sl, logic [15:0] sd, logic [5:0] st, logic [15:0] mm,
    logic [5:0] mt, logic [15:0] td, logic te, logic [5:0] tt, logic le);
    cell_wdata = '{pat, ss, sl, sd, st, mm, 16'h0000, mt, td, te, tt, le};
    cell_addr = a;
    cell_we = 1;
    step();
  endtask : wr
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_start();
    int k;
    `CHK("rst_out", 10'h000, driver_output_n)
    `CHK("rst_run", 1'b0, running_r)
    sys_rst = 0;
    wr(6'h00, 10'h001, 4'h0, 1'b0, 16'h0005, 6'h05, 16'h0000, 6'h00,
       16'h0000, 1'b0, 6'h00, 1'b0);
    wr(6'h05, 10'h081, 4'ha, 1'b1, 16'h0000, 6'h09, 16'h0001, 6'h3e,
       16'h0002, 1'b1, 6'h07, 1'b1);
    wr(6'h3e, 10'h2a5, 4'hb, 1'b1, 16'h0000, 6'h07, 16'h0000, 6'h00,
       16'hffff, 1'b1, 6'h07, 1'b0);
    wr(6'h07, 10'h100, 4'hb, 1'b1, 16'h0000, 6'h00, 16'h0000, 6'h00,
       16'h0003, 1'b1, 6'h02, 1'b0);
    wr(6'h02, 10'h000, 4'hb, 1'b1, 16'h0000, 6'h0a, 16'h0000, 6'h00,
       16'h0000, 1'b0, 6'h00, 1'b0);
    cell_we = 0;
    config_done = 1;
    k = 0;
    while (running_r !== 1'b1 && k < 5100) begin step(); k++; end
    `CHK("start_wait", 1'b1, k >= 4998 && k <= 5004)
    step();
    `CHK("start_state", 6'h00, state_r)
    `CHK("start_pat", 10'h001, driver_output_n)
    $display("test start done");
  endtask : t_start
  task automatic t_seq();
    int k;
    k = 0;
    while (mdl_flt !== 1'b0 && k < 100) begin step(); k++; end
    step(300);
    kill = 1;
    step(10);
    kill = 0;
    step(300);
    `CHK("seq_restart", 6'h00, state_r)
    wait_state(6'h05, 300);
    step();
    `CHK("seq_pat", 10'h081, driver_output_n)
    $display("test sequence done");
  endtask : t_seq
  task automatic t_prio();
    kill = 1;
    secondary_warn = 10'h008;
    wait_state(6'h3e, 5);
    kill = 0;
    secondary_warn = 10'h000;
    step();
    `CHK("prio_pat", 10'h2a5, driver_output_n)
    `CHK("latch_first", 5'h01, fault_latch_first)
    `CHK("latch_second", 5'h00, fault_latch_second)
    tb_flt = 9'h040;
    step(5);
    tb_flt = 9'h000;
    step();
    `CHK("keep_first", 5'h01, fault_latch_first)
    `CHK("keep_second", 5'h00, fault_latch_second)
    live_status = 30'h2345_6789;
    step(2);
    `CHK("status", 30'h2345_6789, status_r)
    $display("test priority done");
  endtask : t_prio
  task automatic t_tmo();
    int k;
    // A one-cycle pin pulse: a level still high in state 7 exits to 0.
    digital_pin = 5'h01;
    step();
    digital_pin = 5'h00;
    wait_state(6'h07, 5);
    // Outputs follow the state one clock later.
    step();
    k = 0;
    while (state_r === 6'h07 && k < 400) begin
      `CHK("tmo_hold", 10'h100, driver_output_n)
      step();
      k++;
    end
    `CHK("tmo_time", 1'b1, k >= 200 && k <= 305)
    `CHK("tmo_state", 6'h02, state_r)
    $display("test timeout done");
  endtask : t_tmo
  task automatic t_host();
    int k;
    logic b;
    drive_src = 20'h0_0039;
    host_drive = 10'h001;
    step(3);
    `CHK("src_host", 1'b1, driver_output_n[0])
    `CHK("src_low", 1'b0, driver_output_n[2])
    b = driver_output_n[1];
    k = 0;
    while (driver_output_n[1] === b && k < 60) begin step(); k++; end
    `CHK("src_clock", 1'b1, k < 60)
    // Input 1 runs in edge mode with a two-tick pulse.
    digital_pin = 5'h02;
    step();
    `CHK("edge_pulse", 1'b1, u_pse_engine.dig_level[1])
    step(250);
    `CHK("edge_end", 1'b0, u_pse_engine.dig_level[1])
    fault_clear = 1;
    step();
    fault_clear = 0;
    step();
    `CHK("clr_first", 5'h00, fault_latch_first)
    // The jump feeds both routes; timeout outranks sequence, so target 0.
    host_jump = 1;
    wait_state(6'h00, 5);
    host_jump = 0;
    $display("test host done");
  endtask : t_host
  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  // Reset is held for six cycles before any cell is written.
  initial begin
    sys_rst = 1; config_done = 0; host_jump = 0; cell_we = 0; kill = 0;
    fault_clear = 0; tb_flt = 9'h000; digital_pin = 5'h00;
    secondary_warn = 10'h000; host_drive = 10'h000; cell_addr = 6'h00;
    drive_src = 20'h0_0000; cell_wdata = '0; live_status = '0;
    step(6);
    t_start();
    t_seq();
    t_prio();
    t_tmo();
    t_host();
    end_sim();
  end
  // The full run needs about 7000 cycles; allow well over twice that.
  initial begin
    #2000000;
    fails++;
    end_sim();
  end
endmodule : pse_engine_tb_top
`default_nettype wire
